// >>> rtl/shifter_timer_flag_bank.sv
/*
  Flag, enable and shifter control register bank of a serial I/O engine
  with four shifters and four timers, plus the four holding buffers.
  Assumes the shifter datapaths and timer counters sit outside on the
  same clock and hand over single-cycle event pulses and live values.
*/
// Chosen here: the strobed register port.
// Function
// [RULE1] Receive: status sets when buffer loaded from shifter, clears on buffer read.
// [RULE2] Transmit: status sets on buffer-to-shifter move or entering transmit; clears on write.
// [RULE3] Match store: status sets on match, clears on buffer read.
// [RULE4] Match continuous: status reads the live shifter-to-buffer comparison.
// [RULE5] Writing one clears status except in match continuous; zero does nothing.
// [RULE6] Receive error: overrun, or start/stop bit at wrong level.
// [RULE7] Transmit error: shifter wants data before software wrote fresh data.
// [RULE8] Match store error: new match before stored match was read.
// [RULE9] Match continuous error: set whenever shifter matches buffer.
// [RULE10] Error clears by writing one; match continuous buffer read also clears.
// [RULE11] 8-bit counter: upper byte zero and decrement sets flag and reloads.
// [RULE12] 8-bit PWM: upper byte zero and decrement sets flag and reloads.
// [RULE13] 16-bit counter: whole count zero and decrement sets flag and reloads.
// [RULE14] Timer flag clears only by writing one.
// [RULE15] Shifter status interrupt when flag set and its enable is one.
// [RULE16] Shifter error interrupt when flag set and its enable is one.
// [RULE17] Timer interrupt when flag set and its enable is one.
// [RULE18] DMA request while status flag set and its DMA enable is one.
// [RULE19] Flag and enable registers use low four bits; upper read zero.
// [RULE20] Four shifter control registers at consecutive words from 0x80.
// [RULE21] Receive copies shifter contents into holding buffer on timer expiry.
// [RULE22] One level interrupt output while any enabled flag stays set.
`timescale 1ns/1ps
`include "shifter_timer_flag_bank_regs.svh"

module shifter_timer_flag_bank (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [11:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  input wire logic [3:0][31:0] shiftData,
  input wire logic [3:0] timerExpire,
  input wire logic [3:0] startStopError,
  output logic [3:0][31:0] holdingBuffer,
  output logic [3:0][31:0] shifterControl,
  input wire shifter_timer_flag_bank_pkg::timer_mode_type [3:0] timerMode,
  input wire logic [3:0][15:0] timerCount,
  input wire logic [3:0] timerDecrement,
  output logic [3:0] timerReload,
  output logic irq,
  output logic [3:0] dmaReq
);
  import shifter_timer_flag_bank_pkg::*;

  // True when the port address selects word idx of a register group
  function automatic logic groupHit(input logic [11:0] a, input logic [11:0] base, input int idx);
    logic [11:0] ofs;
    ofs = 12'(idx) * `REG_STRIDE;
    return a == (base + ofs);
  endfunction

  // Reload condition of one timer for its counting mode
  function automatic logic reloadDue(input timer_mode_type m, input logic [15:0] cnt, input logic dec);
    logic hit;
    hit = 1'b0;
    unique case (m)
      TMODE_CNT8: hit = cnt[15:8] == 8'h00; // [RULE11]
      TMODE_PWM8: hit = cnt[15:8] == 8'h00; // [RULE12]
      TMODE_CNT16: hit = cnt == 16'h0000; // [RULE13]
      TMODE_OFF: hit = 1'b0;
    endcase
    return hit && dec;
  endfunction

  logic [3:0] statusReg, statusNext;
  logic [3:0] errorReg, errorNext;
  logic [3:0] timerFlagReg, timerFlagNext;
  logic [3:0] statusIenReg, errorIenReg, timerIenReg, dmaEnReg;
  logic [3:0][31:0] ctlReg, ctlNext;
  logic [3:0][31:0] bufReg, bufNext;
  logic [31:0] rdDataNext;

  // Register decode
  wire wrStat = wrEn && addr == `SSTAT_OFS;
  wire wrErr = wrEn && addr == `SERR_OFS;
  wire wrTim = wrEn && addr == `TSTAT_OFS;
  wire wrSien = wrEn && addr == `SSIEN_OFS;
  wire wrEien = wrEn && addr == `SEIEN_OFS;
  wire wrTien = wrEn && addr == `TIEN_OFS;
  wire wrSden = wrEn && addr == `SSDEN_OFS;
  wire [3:0] w1cBits = wrData[3:0];

  logic [3:0] ctlHit, bufHit;
  logic [3:0] liveMatch;
  logic [3:0] statusView;
  shifter_mode_type [3:0] mode;

  // Per-shifter decode, mode and live comparison
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ctlHit[i] = groupHit(addr, `SCTL_BASE, i); // [RULE20]
      bufHit[i] = groupHit(addr, `HBUF_BASE, i);
      mode[i] = shifter_mode_type'(ctlReg[i][`MODE_MSB:`MODE_LSB]);
      liveMatch[i] = shiftData[i] == bufReg[i];
      // Continuous match has no latched bit, so software sees the compare
      statusView[i] = mode[i] == SMODE_MCONT ? liveMatch[i] : statusReg[i]; // [RULE4]
    end
  end

  // Shifter flags, buffers and control; every set term wins over a clear
  always_comb begin
    logic rx, tx, ms, mc, exp, rdB, wrB, setS, clrS, setE, clrE, enterTx;
    rx = 1'b0;
    tx = 1'b0;
    ms = 1'b0;
    mc = 1'b0;
    exp = 1'b0;
    rdB = 1'b0;
    wrB = 1'b0;
    setS = 1'b0;
    clrS = 1'b0;
    setE = 1'b0;
    clrE = 1'b0;
    enterTx = 1'b0;
    statusNext = statusReg;
    errorNext = errorReg;
    ctlNext = ctlReg;
    bufNext = bufReg;
    for (int i = 0; i < 4; i++) begin
      rx = mode[i] == SMODE_RX;
      tx = mode[i] == SMODE_TX;
      ms = mode[i] == SMODE_MSTORE;
      mc = mode[i] == SMODE_MCONT;
      exp = timerExpire[i];
      rdB = rdEn && bufHit[i];
      wrB = wrEn && bufHit[i];
      // Entering transmit mode reports an empty buffer at once
      enterTx = wrEn && ctlHit[i] && !tx
        && wrData[`MODE_MSB:`MODE_LSB] == SMODE_TX; // [RULE2]
      setS = (rx && exp) // [RULE1]
        || (tx && exp && !statusReg[i]) // [RULE2]
        || (ms && exp && liveMatch[i]) // [RULE3]
        || enterTx; // [RULE2]
      clrS = (wrStat && w1cBits[i] && !mc) // [RULE5]
        || ((rx || ms) && rdB) // [RULE1] [RULE3]
        || (tx && wrB); // [RULE2]
      statusNext[i] = setS || (statusReg[i] && !clrS);
      setE = (rx && exp && statusReg[i]) // [RULE6]
        || (rx && startStopError[i]) // [RULE6]
        || (tx && exp && statusReg[i]) // [RULE7]
        || (ms && exp && liveMatch[i] && statusReg[i]) // [RULE8]
        || (mc && liveMatch[i]); // [RULE9]
      clrE = (wrErr && w1cBits[i]) || (mc && rdB); // [RULE10]
      errorNext[i] = setE || (errorReg[i] && !clrE);
      if (wrEn && ctlHit[i]) begin
        ctlNext[i] = wrData & `SCTL_MASK;
      end
      // A capture from the shifter beats a software write in the same cycle
      if (rx && exp) begin
        bufNext[i] = shiftData[i]; // [RULE21]
      end else if (wrB) begin
        bufNext[i] = wrData;
      end
    end
  end

  // Timer flags and reload strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      timerReload[i] = reloadDue(timerMode[i], timerCount[i], timerDecrement[i]); // [RULE11] [RULE12] [RULE13]
      timerFlagNext[i] = timerReload[i]
        || (timerFlagReg[i] && !(wrTim && w1cBits[i])); // [RULE14]
    end
  end

  // Read data mux; reserved bits and unmapped words read zero
  always_comb begin
    rdDataNext = `RDATA_RST;
    unique case (addr)
      `SSTAT_OFS: rdDataNext[3:0] = statusView; // [RULE19]
      `SERR_OFS: rdDataNext[3:0] = errorReg;
      `TSTAT_OFS: rdDataNext[3:0] = timerFlagReg;
      `SSIEN_OFS: rdDataNext[3:0] = statusIenReg;
      `SEIEN_OFS: rdDataNext[3:0] = errorIenReg;
      `TIEN_OFS: rdDataNext[3:0] = timerIenReg;
      `SSDEN_OFS: rdDataNext[3:0] = dmaEnReg;
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (ctlHit[i]) begin
            rdDataNext = ctlReg[i];
          end
          if (bufHit[i]) begin
            rdDataNext = bufReg[i];
          end
        end
      end
    endcase
  end

  // Flag and enable state; clock enable freezes everything
  always_ff @(posedge clock) begin
    if (rst) begin
      statusReg <= `FLAG_RST;
      errorReg <= `FLAG_RST;
      timerFlagReg <= `FLAG_RST;
      statusIenReg <= `FLAG_RST;
      errorIenReg <= `FLAG_RST;
      timerIenReg <= `FLAG_RST;
      dmaEnReg <= `FLAG_RST;
    end else if (ce) begin
      statusReg <= statusNext;
      errorReg <= errorNext;
      timerFlagReg <= timerFlagNext;
      if (wrSien) statusIenReg <= wrData[3:0]; // [RULE19]
      if (wrEien) errorIenReg <= wrData[3:0];
      if (wrTien) timerIenReg <= wrData[3:0];
      if (wrSden) dmaEnReg <= wrData[3:0];
    end
  end

  // Control words, holding buffers and the registered read answer
  always_ff @(posedge clock) begin
    if (rst) begin
      ctlReg <= {4{`SCTL_RST}};
      bufReg <= {4{`HBUF_RST}};
      rdData <= `RDATA_RST;
    end else if (ce) begin
      ctlReg <= ctlNext;
      bufReg <= bufNext;
      rdData <= rdEn ? rdDataNext : `RDATA_RST;
    end
  end

  assign holdingBuffer = bufReg;
  assign shifterControl = ctlReg;

  // Request outputs follow the flags as levels
  assign dmaReq = statusView & dmaEnReg; // [RULE18]
  assign irq = |(statusView & statusIenReg) // [RULE15] [RULE22]
    || |(errorReg & errorIenReg) // [RULE16]
    || |(timerFlagReg & timerIenReg); // [RULE17]

endmodule // shifter_timer_flag_bank

// >>> rtl/shifter_timer_flag_bank_pkg.sv
/*
  Types shared by the shifter and timer flag bank: shifter and timer
  mode encodings. Assumes the register header supplies all other numbers.
*/
package shifter_timer_flag_bank_pkg;

  // Shifter mode field encoding
  typedef enum logic [2:0] {
    SMODE_OFF = 3'h0,
    SMODE_RX = 3'h1,
    SMODE_TX = 3'h2,
    SMODE_MSTORE = 3'h4,
    SMODE_MCONT = 3'h5
  } shifter_mode_type;

  // Timer counting mode encoding
  typedef enum logic [1:0] {
    TMODE_OFF = 2'h0,
    TMODE_CNT8 = 2'h1,
    TMODE_PWM8 = 2'h2,
    TMODE_CNT16 = 2'h3
  } timer_mode_type;

endpackage

// >>> rtl/shifter_timer_flag_bank_regs.svh
/*
  Register offsets, field positions, masks and reset values of the
  shifter and timer flag bank. Assumes byte addresses on a 12-bit
  register port with one 32-bit word per register.
*/
`ifndef SHIFTER_TIMER_FLAG_BANK_REGS_SVH
`define SHIFTER_TIMER_FLAG_BANK_REGS_SVH

// Register byte offsets
`define SSTAT_OFS 12'h010
`define SERR_OFS 12'h014
`define TSTAT_OFS 12'h018
`define SSIEN_OFS 12'h020
`define SEIEN_OFS 12'h024
`define TIEN_OFS 12'h028
`define SSDEN_OFS 12'h030
`define SCTL_BASE 12'h080
`define HBUF_BASE 12'h200
`define REG_STRIDE 12'h004

// Flag registers hold one bit per unit in the low four bits
`define FLAG_MASK 32'h0000000f
// Writable bits of a shifter control word; the rest read zero
`define SCTL_MASK 32'h03830787
`define MODE_LSB 0
`define MODE_MSB 2

// Reset values
`define FLAG_RST 4'h0
`define SCTL_RST 32'h00000000
`define HBUF_RST 32'h00000000
`define RDATA_RST 32'h00000000

`endif

// >>> verif/flag_bank_props.sv
/* Port checker for the shifter and timer flag bank.
   Assumes the package and the register header are compiled first. */
`timescale 1ns/1ps
`include "shifter_timer_flag_bank_regs.svh"
module flag_bank_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [11:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [31:0] rdData,
  input wire shifter_timer_flag_bank_pkg::timer_mode_type [3:0] timerMode,
  input wire logic [3:0][15:0] timerCount,
  input wire logic [3:0] timerDecrement,
  input wire logic [3:0] timerReload,
  input wire logic [3:0] dmaReq
);
  import shifter_timer_flag_bank_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Reads of flag and enable words, whose upper bits must stay zero
  wire flagRead = ce && rdEn && addr inside {`SSTAT_OFS, `SERR_OFS, `TSTAT_OFS,
    `SSIEN_OFS, `SEIEN_OFS, `TIEN_OFS, `SSDEN_OFS};
  sequence s_reload; ce && timerReload[0]; endsequence
  sequence s_stat_read; ce && rdEn && addr == `TSTAT_OFS; endsequence
  property p_unmapped; ce && rdEn && addr == 12'h00c |=> rdData == 32'h0; endproperty
  property p_upper; flagRead |=> rdData[31:4] == 28'h0; endproperty
  property p_cnt8; timerMode[0] == TMODE_CNT8 |->
    timerReload[0] == (timerCount[0][15:8] == 8'h0 && timerDecrement[0]); endproperty
  property p_pwm8; timerMode[0] == TMODE_PWM8 |->
    timerReload[0] == (timerCount[0][15:8] == 8'h0 && timerDecrement[0]); endproperty
  property p_cnt16; timerMode[0] == TMODE_CNT16 |->
    timerReload[0] == (timerCount[0] == 16'h0 && timerDecrement[0]); endproperty
  property p_off; timerMode[0] == TMODE_OFF |-> !timerReload[0]; endproperty
  property p_tsf; s_reload ##1 s_stat_read |=> rdData[0]; endproperty
  property p_dma; ce && wrEn && addr == `SSDEN_OFS && wrData[3:0] == 4'h0 |=> dmaReq == 4'h0; endproperty
  property p_freeze; !ce |=> $stable(rdData) && $stable(dmaReq); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_upper: assert property (p_upper) else $error("reserved bits not zero");
  a_cnt8: assert property (p_cnt8) else $error("8-bit counter reload wrong");
  a_pwm8: assert property (p_pwm8) else $error("8-bit pwm reload wrong");
  a_cnt16: assert property (p_cnt16) else $error("16-bit counter reload wrong");
  a_off: assert property (p_off) else $error("reload with timer off");
  a_tsf: assert property (p_tsf) else $error("timer flag not set by reload");
  a_dma: assert property (p_dma) else $error("dma request while disabled");
endmodule // flag_bank_props

// >>> verif/serial_engine_model.sv
/* Behavioural shifter and timer engine facing the flag bank.
   Assumes the bench sets shift data and timer modes between edges. */
`timescale 1ns/1ps
module serial_engine_model (
  input wire logic clock,
  output logic [3:0][31:0] shiftData,
  output logic [3:0] timerExpire,
  output logic [3:0] startStopError,
  output shifter_timer_flag_bank_pkg::timer_mode_type [3:0] timerMode,
  output logic [3:0][15:0] timerCount,
  output logic [3:0] timerDecrement,
  input wire logic [3:0] timerReload
);
  import shifter_timer_flag_bank_pkg::*;
  initial begin
    shiftData = '0;
    timerExpire = 4'h0;
    startStopError = 4'h0;
    timerCount = '0;
    timerDecrement = 4'h0;
    foreach (timerMode[i]) timerMode[i] = TMODE_OFF;
  end
  // Timer 0 ticks every cycle; a short compare value keeps reloads frequent
  always @(posedge clock) begin
    timerDecrement <= 4'h1;
    timerCount[0] <= (timerReload[0] || timerCount[0] == 16'h0) ? 16'h0003 : timerCount[0] - 16'h0001;
  end
  // One-cycle expiry and framing-error pulses
  task pulse(input logic [3:0] ex, input logic [3:0] se);
    timerExpire <= ex;
    startStopError <= se;
    @(posedge clock);
    timerExpire <= 4'h0;
    startStopError <= 4'h0;
  endtask
endmodule // serial_engine_model

// >>> verif/tb.sv
/* Self-checking bench for the flag bank with a queue of expected reads.
   Assumes the package, header, engine model and checker are compiled. */
`timescale 1ns/1ps
`include "shifter_timer_flag_bank_regs.svh"
module tb;
  import shifter_timer_flag_bank_pkg::*;
  localparam logic [11:0] REGS [7] = '{`SSTAT_OFS, `SERR_OFS, `TSTAT_OFS, `SSIEN_OFS, `SEIEN_OFS, `TIEN_OFS, `SSDEN_OFS};
  localparam logic [2:0] MODES [4] = '{SMODE_RX, SMODE_TX, SMODE_MSTORE, SMODE_MCONT};
  localparam timer_mode_type TMS [3] = '{TMODE_CNT8, TMODE_PWM8, TMODE_CNT16};
  logic clock = 1'b0, rst = 1'b1, ce = 1'b1, wrEn = 1'b0, rdEn = 1'b0, rdSeen = 1'b0, irq;
  logic [11:0] addr = 12'h0;
  logic [31:0] wrData = 32'h0, rdData, d0, v;
  logic [31:0] expQ [$];
  logic [3:0][31:0] shiftData, holdingBuffer, shifterControl;
  logic [3:0] timerExpire, startStopError, timerDecrement, timerReload, dmaReq;
  timer_mode_type [3:0] timerMode;
  logic [3:0][15:0] timerCount;
  int miscompares = 0, checksDone = 0;
  shifter_timer_flag_bank uut (.*);
  serial_engine_model eng (.*);
  initial forever #50 clock = ~clock;
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Answers land one cycle after the strobe, oldest note first
  always @(posedge clock) begin
    if (rdSeen) chk("rdData", expQ.pop_front(), rdData);
    rdSeen <= rdEn && ce;
  end
  // Bus tasks are entered just after an edge and leave at the next one
  task wr(input logic [11:0] a, input logic [31:0] d);
    addr <= a; wrData <= d; wrEn <= 1'b1; rdEn <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    addr <= a; rdEn <= 1'b1; wrEn <= 1'b0;
    @(posedge clock);
  endtask
  task idle(input int n);
    wrEn <= 1'b0; rdEn <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  // Let the edge's updates settle before looking at level outputs
  task late();
    idle(1);
    #1;
  endtask
  task ev(input logic [3:0] ex, input logic [3:0] se);
    wrEn <= 1'b0; rdEn <= 1'b0;
    eng.pulse(ex, se);
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    stop_test();
  end
  initial begin
    v = $urandom(71096);
    d0 = $urandom();
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    eng.shiftData <= {32'h1, 32'h0, $urandom(), d0};
    foreach (REGS[i]) rd(REGS[i], 32'h0);
    rd(12'h00c, 32'h0);
    for (int i = 3; i < 7; i++) begin
      v = $urandom();
      wr(REGS[i], v);
      rd(REGS[i], v & `FLAG_MASK);
      wr(REGS[i], 32'h0);
    end
    // One shifter in each mode; entering transmit raises its status
    for (int i = 0; i < 4; i++) begin
      v = $urandom();
      v[2:0] = MODES[i];
      wr(`SCTL_BASE + 12'(4 * i), v);
      rd(`SCTL_BASE + 12'(4 * i), v & `SCTL_MASK);
    end
    chk("shifterControl", v & `SCTL_MASK, shifterControl[3]);
    // A frozen block must ignore a write
    ce <= 1'b0;
    wr(`SSIEN_OFS, 32'hf);
    ce <= 1'b1;
    rd(`SSIEN_OFS, 32'h0);
    rd(`SSTAT_OFS, 32'h2);
    ev(4'h7, 4'h0);
    rd(`SSTAT_OFS, 32'h7);
    rd(`SERR_OFS, 32'h2);
    ev(4'h5, 4'h0);
    rd(`SERR_OFS, 32'h7);
    rd(`HBUF_BASE, d0);
    chk("holdingBuffer", d0, holdingBuffer[0]);
    rd(`HBUF_BASE + 12'h8, 32'h0);
    wr(`HBUF_BASE + 12'h4, $urandom());
    rd(`SSTAT_OFS, 32'h0);
    wr(`SERR_OFS, 32'h5);
    rd(`SERR_OFS, 32'h2);
    wr(`SERR_OFS, 32'h0);
    rd(`SERR_OFS, 32'h2);
    wr(`SERR_OFS, 32'h2);
    ev(4'h1, 4'h0);
    late();
    chk("irq", 32'h0, 32'(irq));
    wr(`SSIEN_OFS, 32'h1);
    late();
    chk("irq", 32'h1, 32'(irq));
    wr(`SSDEN_OFS, 32'h1);
    late();
    chk("dmaReq", 32'h1, 32'(dmaReq));
    wr(`SSIEN_OFS, 32'h0);
    wr(`SSDEN_OFS, 32'h0);
    wr(`SSTAT_OFS, 32'h0);
    rd(`SSTAT_OFS, 32'h1);
    wr(`SSTAT_OFS, 32'h1);
    rd(`SSTAT_OFS, 32'h0);
    ev(4'h0, 4'h1);
    wr(`SEIEN_OFS, 32'h1);
    late();
    chk("irq", 32'h1, 32'(irq));
    wr(`SEIEN_OFS, 32'h0);
    wr(`SERR_OFS, 32'h1);
    rd(`SERR_OFS, 32'h0);
    // Continuous match follows the live compare and ignores clearing writes
    eng.shiftData[3] <= 32'h0;
    idle(1);
    rd(`SSTAT_OFS, 32'h8);
    rd(`SERR_OFS, 32'h8);
    wr(`SSTAT_OFS, 32'h8);
    rd(`SSTAT_OFS, 32'h8);
    eng.shiftData[3] <= 32'h1;
    idle(1);
    rd(`SSTAT_OFS, 32'h0);
    rd(`HBUF_BASE + 12'hc, 32'h0);
    rd(`SERR_OFS, 32'h0);
    foreach (TMS[i]) begin
      eng.timerMode[0] <= TMS[i];
      idle(6);
    end
    repeat (4) rd(`TSTAT_OFS, 32'h1);
    eng.timerMode[0] <= TMODE_OFF;
    idle(2);
    wr(`TSTAT_OFS, 32'h0);
    rd(`TSTAT_OFS, 32'h1);
    wr(`TIEN_OFS, 32'h1);
    late();
    chk("irq", 32'h1, 32'(irq));
    wr(`TSTAT_OFS, 32'h1);
    rd(`TSTAT_OFS, 32'h0);
    late();
    chk("irq", 32'h0, 32'(irq));
    idle(2);
    stop_test();
  end
endmodule // tb

bind shifter_timer_flag_bank flag_bank_props u_props (.*);
